// [slcs_defs.vh]
`ifndef SLCS_DEFS_VH
`define SLCS_DEFS_VH

// Register byte addresses
`define SLCS_ADDR_CTRL     8'h00
`define SLCS_ADDR_STATUS   8'h04

// Control register fields
`define SLCS_CTRL_EQUIP    0
`define SLCS_CTRL_FAC      1
`define SLCS_CTRL_BYPASS   2
`define SLCS_CTRL_RECREF   3
`define SLCS_CTRL_HIRATE   4
`define SLCS_CTRL_RATIO_LO 5
`define SLCS_CTRL_RATIO_HI 7
`define SLCS_CTRL_RESET    8'h00

// Status register fields
`define SLCS_ST_LOSS       0
`define SLCS_ST_RECREF     1
`define SLCS_ST_LOCK       2
`define SLCS_ST_FULL       3
`define SLCS_ST_EMPTY      4
`define SLCS_ST_BADRATIO   5
`define SLCS_ST_DIV_LO     8
`define SLCS_ST_DIV_HI     13

// Ratio select patterns {bit2,bit1,bit0}
`define SLCS_SEL_19M       3'h6
`define SLCS_SEL_38M       3'h2
`define SLCS_SEL_51M       3'h1
`define SLCS_SEL_77M       3'h0

// Feedback divide ratios
`define SLCS_DIV_19M       6'h20
`define SLCS_DIV_38M       6'h10
`define SLCS_DIV_51M       6'h0C
`define SLCS_DIV_77M       6'h08

// Synthesized bit tick counter last count (tick spacing minus one clk cycle), high and low line rate
`define SLCS_SYN_HI_LAST   4'h1
`define SLCS_SYN_LO_LAST   4'h7

// Bits per byte, last bit index
`define SLCS_BIT_LAST      3'h7
`define SLCS_IDLE_BYTE     8'h00
`define SLCS_FIFO_DEPTH    32
`define SLCS_FIFO_AW       5

`endif

// [slcs_fifo.v]
`default_nettype none

module slcs_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rst,
	// Fill side
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output reg              inReady,
	// Drain side
	output wire [WIDTH-1:0] outData,
	output reg              outValid,
	input  wire             outReady
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wrPtr;
	reg [AW-1:0]    rdPtr;
	reg [AW:0]      count;
	reg [AW:0]      next_count;
	wire            push;
	wire            pop;

	assign push    = inValid & inReady;
	assign pop     = outValid & outReady;
	assign outData = mem[rdPtr];

	always @*
	begin
		next_count = count;
		if (push & ~pop)
			next_count = count + 1'b1;
		else if (pop & ~push)
			next_count = count - 1'b1;
	end

	always @(posedge clk)
	begin
		if (push)
			mem[wrPtr] <= inData;
	end

	// Flags registered from the next count so both ports see honest full/empty
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wrPtr    <= {AW{1'b0}};
			rdPtr    <= {AW{1'b0}};
			count    <= {(AW+1){1'b0}};
			inReady  <= 1'b1;
			outValid <= 1'b0;
		end
		else
		begin
			if (push)
				wrPtr <= wrPtr + 1'b1;
			if (pop)
				rdPtr <= rdPtr + 1'b1;
			count    <= next_count;
			inReady  <= (next_count != DEPTH[AW:0]);
			outValid <= (next_count != {(AW+1){1'b0}});
		end
	end

endmodule

`default_nettype wire

// [slcs_top.v]
`include "slcs_defs.vh"
`default_nettype none

module slcs_top (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Framer transmit side
	input  wire [7:0]  txParallelIn,
	input  wire        txParallelValid,
	output wire        txParallelReady,
	output reg         txByteClockOut,
	// Framer receive side
	output reg  [7:0]  rxParallelOut,
	output reg         rxByteClockOut,
	// Optics serial side
	input  wire        rxSerialIn,
	input  wire        rxSerialClockIn,
	output reg         txSerialOut,
	output reg         txSerialClockOut,
	// Reference and loss inputs
	input  wire        referenceClockIn,
	input  wire        signalLossLevelIn,
	input  wire        signalLossPolarityIn
);

	////////////////////////////////////////////////////////////////////////
	// Ratio decode

	function [5:0] ratioDivide;
		input [2:0] sel;
		begin
			case (sel)
				`SLCS_SEL_19M: ratioDivide = `SLCS_DIV_19M;
				`SLCS_SEL_38M: ratioDivide = `SLCS_DIV_38M;
				`SLCS_SEL_51M: ratioDivide = `SLCS_DIV_51M;
				`SLCS_SEL_77M: ratioDivide = `SLCS_DIV_77M;
				default:       ratioDivide = 6'h00;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Control and derived modes

	reg  [7:0] ctrl;
	wire       equipmentLoopEnable;
	wire       facilityLoopEnable;
	wire       cmuBypassLoopTiming;
	wire       recoveredReferenceLoopTiming;
	wire       highRateSelect;
	wire [2:0] ratioSelect;
	wire [5:0] divRaw;
	wire [5:0] divRatio;
	wire       badRatio;
	wire       signalLoss;
	wire       recRefActive;

	assign equipmentLoopEnable          = ctrl[`SLCS_CTRL_EQUIP];
	assign facilityLoopEnable           = ctrl[`SLCS_CTRL_FAC];
	assign cmuBypassLoopTiming          = ctrl[`SLCS_CTRL_BYPASS];
	assign recoveredReferenceLoopTiming = ctrl[`SLCS_CTRL_RECREF];
	assign highRateSelect               = ctrl[`SLCS_CTRL_HIRATE];
	assign ratioSelect                  = ctrl[`SLCS_CTRL_RATIO_HI:`SLCS_CTRL_RATIO_LO];

	assign divRaw   = ratioDivide(ratioSelect);
	assign badRatio = (divRaw == 6'h00);
	// Undefined pattern falls back to the 77.76 MHz ratio
	assign divRatio = badRatio ? `SLCS_DIV_77M : divRaw;

	assign signalLoss   = ~(signalLossLevelIn ^ signalLossPolarityIn);
	// Never let the multiplier lock to its own looped output
	assign recRefActive = recoveredReferenceLoopTiming & ~signalLoss & ~equipmentLoopEnable;

	////////////////////////////////////////////////////////////////////////
	// Input edge detection (inputs are synchronous to clk)

	reg  rxClkPrev;
	reg  refClkPrev;
	wire rxClkRise;
	wire refClkRise;

	assign rxClkRise  = rxSerialClockIn & ~rxClkPrev;
	assign refClkRise = referenceClockIn & ~refClkPrev;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rxClkPrev  <= 1'b0;
			refClkPrev <= 1'b0;
		end
		else
		begin
			rxClkPrev  <= rxSerialClockIn;
			refClkPrev <= referenceClockIn;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock multiplier model: synthesized bit tick, feedback divider, lock

	reg  [3:0] synCnt;
	reg  [5:0] fbCnt;
	reg  [2:0] rxDivCnt;
	reg        locked;
	wire [3:0] synLast;
	wire       synthTick;
	wire       bitTick;
	wire       rxByteTick;
	wire       refEdge;

	assign synLast    = highRateSelect ? `SLCS_SYN_HI_LAST : `SLCS_SYN_LO_LAST;
	assign synthTick  = (synCnt == synLast);
	assign bitTick    = cmuBypassLoopTiming ? rxClkRise : synthTick;
	assign rxByteTick = rxClkRise & (rxDivCnt == `SLCS_BIT_LAST);
	assign refEdge    = recRefActive ? rxByteTick : refClkRise;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			synCnt   <= 4'h0;
			fbCnt    <= 6'h00;
			rxDivCnt <= 3'h0;
			locked   <= 1'b0;
		end
		else
		begin
			synCnt <= synthTick ? 4'h0 : synCnt + 1'b1;
			if (rxClkRise)
				rxDivCnt <= rxDivCnt + 1'b1;
			// Phase comparison: reference edge must meet the divider wrap
			if (refEdge)
			begin
				locked <= (fbCnt == 6'h00);
				fbCnt  <= (synthTick && divRatio != 6'h01) ? 6'h01 : 6'h00;
			end
			else if (synthTick)
				fbCnt <= (fbCnt == divRatio - 1'b1) ? 6'h00 : fbCnt + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit FIFO

	wire [7:0] fifoData;
	wire       fifoValid;
	wire       fifoPop;
	reg  [2:0] serCnt;

	assign fifoPop = bitTick & (serCnt == 3'h0);

	slcs_fifo #(
		.WIDTH (8),
		.DEPTH (`SLCS_FIFO_DEPTH),
		.AW    (`SLCS_FIFO_AW)
	) i_slcs_fifo (
		.clk      (clk),
		.rst      (rst),
		.inData   (txParallelIn),
		.inValid  (txParallelValid),
		.inReady  (txParallelReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (fifoPop)
	);

	////////////////////////////////////////////////////////////////////////
	// Serializer, MSB first; idle byte sent when the FIFO runs dry

	reg  [7:0] serShift;
	reg        serBit;
	wire [7:0] serLoad;

	assign serLoad = fifoValid ? fifoData : `SLCS_IDLE_BYTE;

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			serShift       <= 8'h00;
			serBit         <= 1'b0;
			serCnt         <= 3'h0;
			txByteClockOut <= 1'b0;
		end
		else if (bitTick)
		begin
			serCnt         <= serCnt + 1'b1;
			txByteClockOut <= serCnt[2];
			if (serCnt == 3'h0)
			begin
				serBit   <= serLoad[7];
				serShift <= {serLoad[6:0], 1'b0};
			end
			else
			begin
				serBit   <= serShift[7];
				serShift <= {serShift[6:0], 1'b0};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial transmit output select

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			txSerialOut      <= 1'b0;
			txSerialClockOut <= 1'b0;
		end
		else if (facilityLoopEnable)
		begin
			// Serializer output is dropped here, also in split loopback
			txSerialOut      <= rxSerialIn;
			txSerialClockOut <= rxSerialClockIn;
		end
		else
		begin
			txSerialOut      <= serBit;
			txSerialClockOut <= bitTick;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Deserializer and receive byte output

	reg  [7:0] desShift;
	reg  [2:0] desCnt;
	wire       desTick;
	wire       desBit;
	wire [7:0] desByte;

	// Equipment loop takes serializer bits on bitTick (synthesized tick, or rx clock rise in bypass)
	assign desTick = equipmentLoopEnable ? bitTick : rxClkRise;
	assign desBit  = equipmentLoopEnable ? serBit : rxSerialIn;
	assign desByte = {desShift[6:0], desBit};

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			desShift       <= 8'h00;
			desCnt         <= 3'h0;
			rxParallelOut  <= 8'h00;
			rxByteClockOut <= 1'b0;
		end
		else
		begin
			if (desTick)
			begin
				desShift       <= desByte;
				desCnt         <= desCnt + 1'b1;
				rxByteClockOut <= desCnt[2];
			end
			if (signalLoss)
				rxParallelOut <= 8'h00;
			else if (desTick && desCnt == `SLCS_BIT_LAST)
				rxParallelOut <= desByte;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, write lands on the completing edge

	wire        access;
	wire        addrOk;
	reg  [31:0] readMux;

	assign access = psel & penable;
	assign addrOk = (paddr == `SLCS_ADDR_CTRL) | (paddr == `SLCS_ADDR_STATUS);

	always @*
	begin
		readMux = 32'h00000000;
		case (paddr)
			`SLCS_ADDR_CTRL:
				readMux[7:0] = ctrl;
			`SLCS_ADDR_STATUS:
			begin
				readMux[`SLCS_ST_LOSS]     = signalLoss;
				readMux[`SLCS_ST_RECREF]   = recRefActive;
				readMux[`SLCS_ST_LOCK]     = locked;
				readMux[`SLCS_ST_FULL]     = ~txParallelReady;
				readMux[`SLCS_ST_EMPTY]    = ~fifoValid;
				readMux[`SLCS_ST_BADRATIO] = badRatio;
				readMux[`SLCS_ST_DIV_HI:`SLCS_ST_DIV_LO] = divRatio;
			end
			default:
				readMux = 32'h00000000;
		endcase
	end

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl    <= `SLCS_CTRL_RESET;
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (access && !pready)
		begin
			pready  <= 1'b1;
			prdata  <= pwrite ? 32'h00000000 : readMux;
			pslverr <= ~addrOk;
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			if (access && pwrite && paddr == `SLCS_ADDR_CTRL)
				ctrl <= pwdata[7:0];
		end
	end

endmodule

`default_nettype wire

// [slcs_props.sv]
`default_nettype none
module slcs_props (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Streams and pins
	input wire logic        txParallelValid,
	input wire logic        txParallelReady,
	input wire logic [7:0]  rxParallelOut,
	input wire logic        rxSerialClockIn,
	input wire logic        txSerialClockOut,
	input wire logic        signalLossLevelIn,
	input wire logic        signalLossPolarityIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ctl;
	wire        loss = signalLossLevelIn ~^ signalLossPolarityIn;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	// Shadow of the control word, taken at the completing edge
	always @(posedge clk or posedge rst)
		if (rst)
			ctl <= 8'h00;
		else if (psel && penable && pready && pwrite && paddr == 8'h00)
			ctl <= pwdata[7:0];
	////////////////////////////////////////////////////////////////
	a_loss_rx_low: assert property (loss ##1 loss |-> rxParallelOut == 8'h00)
		else $error("rx data not forced low");
	a_pready_once: assert property (pready |=> !pready)
		else $error("pready held");
	a_pready_due: assert property (psel && penable && !pready |=> pready)
		else $error("pready late");
	a_pready_cause: assert property ($rose(pready) |-> $past(psel && penable))
		else $error("pready unasked");
	a_err_map: assert property (pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04))
		else $error("pslverr wrong");
	a_ctl_read: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata == {24'h0, ctl})
		else $error("ctrl readback wrong");
	a_fill_cause: assert property ($fell(txParallelReady) |-> $past(txParallelValid))
		else $error("ready fell unpushed");
	a_fac_clock: assert property (ctl[1] ##1 ctl[1] |-> txSerialClockOut == $past(rxSerialClockIn))
		else $error("serial clock not looped");
	a_recref_off: assert property (pready && !pwrite && paddr == 8'h04 && ctl[0] |-> !prdata[1])
		else $error("recovered ref kept");
	a_div_low: assert property (pready && !pwrite && paddr == 8'h04 && ctl[7:5] == 3'h6 |-> prdata[13:8] == 6'h20)
		else $error("divide ratio wrong");
	c_err: cover property (pready && pslverr);
	c_split: cover property (ctl[0] && ctl[1]);
	c_full: cover property (!txParallelReady);
	c_equip_byte: cover property (ctl[0] && rxParallelOut == 8'hFF);
endmodule
`default_nettype wire

// [slcs_optics.sv]
`default_nettype none
module slcs_optics (
	// Clock
	input wire logic       clk,
	// Bench control
	input wire logic       run,
	input wire logic       lossOn,
	input wire logic       lossPol,
	input wire logic [7:0] pattern,
	// Optics pins
	output var logic       rxSerialIn,
	output var logic       rxSerialClockIn,
	output var logic       signalLossLevelIn,
	output wire logic      signalLossPolarityIn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph;
	logic [2:0] ix;
	initial
	begin
		{rxSerialIn, rxSerialClockIn, signalLossLevelIn, ph, ix} = 8'h07;
	end
	assign signalLossPolarityIn = lossPol;
	always @(posedge clk)
	begin
		signalLossLevelIn <= lossOn ~^ lossPol;
		// Clock stands still between frames; data keeps moving
		if (!run)
		begin
			ph <= 2'h0;
			rxSerialClockIn <= 1'b0;
			rxSerialIn <= ~rxSerialIn;
		end
		else
		begin
			ph <= ph + 2'h1;
			rxSerialClockIn <= ph[1];
			if (ph == 2'h0)
			begin
				rxSerialIn <= pattern[ix];
				ix <= ix - 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [slcs_top_tb.sv]
`include "slcs_defs.vh"
`default_nettype none
module slcs_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, psel, penable, pwrite, txParallelValid, run, lossOn, lossPol, er;
	logic [7:0]  paddr, txParallelIn, pattern;
	logic [31:0] pwdata, rd;
	logic [2:0]  refCnt;
	wire  [31:0] prdata;
	wire  [7:0]  rxParallelOut;
	wire         pready, pslverr, txParallelReady, txByteClockOut, rxByteClockOut;
	wire         rxSerialIn, rxSerialClockIn, txSerialOut, txSerialClockOut, lvl, pol;
	int          num_errors, comparisons, n, i, nClk, nOne, nNz, nFF, nChg, nTxb;
	logic [2:0]  sel [5] = '{`SLCS_SEL_19M, `SLCS_SEL_38M, `SLCS_SEL_51M, `SLCS_SEL_77M, 3'h7};
	logic [5:0]  dv [5] = '{`SLCS_DIV_19M, `SLCS_DIV_38M, `SLCS_DIV_51M, `SLCS_DIV_77M, `SLCS_DIV_77M};
	slcs_top i_slcs_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.txParallelIn(txParallelIn), .txParallelValid(txParallelValid), .txParallelReady(txParallelReady),
		.txByteClockOut(txByteClockOut), .rxParallelOut(rxParallelOut), .rxByteClockOut(rxByteClockOut),
		.rxSerialIn(rxSerialIn), .rxSerialClockIn(rxSerialClockIn), .txSerialOut(txSerialOut),
		.txSerialClockOut(txSerialClockOut), .referenceClockIn(refCnt[2]),
		.signalLossLevelIn(lvl), .signalLossPolarityIn(pol));
	slcs_optics i_slcs_optics (.clk(clk), .run(run), .lossOn(lossOn), .lossPol(lossPol), .pattern(pattern),
		.rxSerialIn(rxSerialIn), .rxSerialClockIn(rxSerialClockIn), .signalLossLevelIn(lvl),
		.signalLossPolarityIn(pol));
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		refCnt <= refCnt + 3'h1;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic ok(input logic c);
		chk({31'h0, c}, 32'h1);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog may end a wait for the answer
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	task automatic push(input int k);
		txParallelIn <= 8'hFF;
		txParallelValid <= 1'b1;
		repeat (k)
			do @(posedge clk); while (txParallelReady !== 1'b1);
		txParallelValid <= 1'b0;
	endtask
	task automatic watch(input int k);
		logic b;
		logic t;
		b = rxByteClockOut;
		t = txByteClockOut;
		{nClk, nOne, nNz, nFF, nChg, nTxb} = '0;
		repeat (k)
		begin
			@(posedge clk);
			nClk += txSerialClockOut;
			nOne += txSerialOut;
			nNz += (rxParallelOut !== 8'h00);
			nFF += (rxParallelOut === 8'hFF);
			nChg += (rxByteClockOut !== b);
			b = rxByteClockOut;
			nTxb += (txByteClockOut !== t);
			t = txByteClockOut;
		end
	endtask
	task automatic conclude;
		if (num_errors == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#100us;
		num_errors++;
		conclude;
	end
	initial
	begin
		{rst, psel, penable, pwrite, paddr, pwdata, txParallelIn, txParallelValid} = {4'h8, 49'h0};
		{run, lossOn, lossPol, pattern, refCnt} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(8'h00, 32'hFFFF_FFFF, 32'h0);
		rdc(8'h04, 32'h18, 32'h10);
		apb(1'b1, 8'h04, 32'hFFFF);
		ok(er === 1'b0);
		apb(1'b0, 8'h08, 32'h0);
		ok(er === 1'b1 && rd === 32'h0);
		for (i = 0; i < 5; i++)
		begin
			apb(1'b1, 8'h00, {24'h0, sel[i], i[0], 4'h0});
			rdc(8'h04, 32'h3F20, {18'h0, dv[i], 2'h0, i == 4, 5'h0});
		end
		for (i = 0; i < 4; i++)
		begin
			{lossPol, lossOn} <= i[1:0];
			repeat (4) @(posedge clk);
			rdc(8'h04, 32'h1, {31'h0, i[0]});
		end
		apb(1'b1, 8'h00, 32'h08);
		rdc(8'h04, 32'h2, 32'h0);
		lossOn <= 1'b0;
		rdc(8'h04, 32'h2, 32'h2);
		apb(1'b1, 8'h00, 32'h09);
		rdc(8'h04, 32'h2, 32'h0);
		apb(1'b1, 8'h00, 32'h11);
		push(8);
		watch(200);
		ok(nFF > 0);
		ok(nOne > 0);
		ok(nChg > 0);
		ok(nClk > 90);
		ok(nTxb > 20);
		pattern <= 8'hFF;
		run <= 1'b1;
		apb(1'b1, 8'h00, 32'h13);
		watch(40);
		watch(100);
		ok(nNz == 0);
		ok(nOne > 90);
		// Facility alone still fills the receive port, so loss has data to blank
		apb(1'b1, 8'h00, 32'h02);
		watch(80);
		ok(nFF > 0);
		lossOn <= 1'b1;
		watch(2);
		watch(40);
		ok(nNz == 0);
		lossOn <= 1'b0;
		apb(1'b1, 8'h00, 32'h04);
		run <= 1'b0;
		watch(8);
		watch(40);
		ok(nClk == 0);
		ok(nTxb == 0);
		run <= 1'b1;
		watch(40);
		ok(nClk > 0);
		run <= 1'b0;
		apb(1'b1, 8'h00, 32'h00);
		txParallelValid <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n += txParallelReady;
		end while (txParallelReady === 1'b1 && n < 40);
		txParallelValid <= 1'b0;
		ok(n >= 32 && n <= 34);
		repeat (2400) @(posedge clk);
		rdc(8'h04, 32'h18, 32'h10);
		conclude;
	end
endmodule
bind slcs_top slcs_props i_slcs_props (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.txParallelValid(txParallelValid), .txParallelReady(txParallelReady), .rxParallelOut(rxParallelOut),
	.rxSerialClockIn(rxSerialClockIn), .txSerialClockOut(txSerialClockOut),
	.signalLossLevelIn(signalLossLevelIn), .signalLossPolarityIn(signalLossPolarityIn));
`default_nettype wire
